// >>> hw/scs_cfg.svh
`ifndef SCS_CFG_SVH
`define SCS_CFG_SVH

// Width of a channel number; channel zero is the home position.
`define SCS_CHAN_W      8
// Width of one stored measurement word.
`define SCS_DATA_W      16
// Width of the settling delay count, in clock cycles of the 10 MHz clock.
`define SCS_DELAY_W     16
// Channel number that stands for home, with every channel open.
`define SCS_HOME_CHAN   8'h00
// First channel of every scan pass.
`define SCS_FIRST_CHAN  8'h01
// Reset value of the stored final channel.
`define SCS_LAST_RST    8'h01
// Reset value of the stored measurement word.
`define SCS_DATA_RST    16'h0000
// Reset value of the settling counter.
`define SCS_DELAY_RST   16'h0000
// Count step of the settling counter.
`define SCS_DELAY_STEP  16'h0001

`endif

// >>> hw/scs_pkg.sv
package scs_pkg;

  // Operating mode carried by a programming command.
  typedef enum logic [1:0] {
    SCS_MODE_SINGLE,
    SCS_MODE_CONT,
    SCS_MODE_RANDOM
  } scs_mode_t;

endpackage

// >>> hw/scs_settle_timer.sv
`timescale 1ns/1ps
`include "scs_cfg.svh"

// Channel settling timer. A start pulse loads the front-panel delay and the
// done pulse asks the meter to measure once the count has run out.
module scs_settle_timer
  import scs_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    srst,
  input  wire logic                    start,
  input  wire logic [`SCS_DELAY_W-1:0] delay,
  output logic                         busy,
  output logic                         done
);

  logic [`SCS_DELAY_W-1:0] cnt_ff;     // Cycles left before the measurement.
  logic                    busy_ff;    // High while the delay runs.
  logic                    done_ff;    // One-cycle end-of-delay pulse.
  logic [`SCS_DELAY_W-1:0] nxt_cnt;
  logic                    nxt_busy;
  logic                    nxt_done;
  wire                     expire;     // Last cycle of a running delay.

  // A zero delay still expires one cycle after the start, never in it.
  assign expire   = busy_ff && (cnt_ff == `SCS_DELAY_RST);
  // A new start restarts the delay, since the channel has just changed.
  assign nxt_cnt  = start ? delay : (busy_ff && !expire) ? cnt_ff - `SCS_DELAY_STEP : cnt_ff;
  assign nxt_busy = start | (busy_ff & ~expire);
  assign nxt_done = expire & ~start;

  // Counter registers.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      cnt_ff  <= `SCS_DELAY_RST;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end
    else
    begin
      cnt_ff  <= nxt_cnt;
      busy_ff <= nxt_busy;
      done_ff <= nxt_done;
    end
  end

  assign busy = busy_ff;
  assign done = done_ff;

endmodule

// >>> hw/scs_sequencer.sv
// Contract
// - Single scan runs once, channel 1 to final.
// - Single scan never wraps without new programming.
// - Scan-mode programming while ready clears ready, selects 1.
// - End of programming strobes store, starts settling; settling here starts only when programmed while ready.
// - Programming while not ready selects no channel.
// - Scan-mode advance moves to next channel, starts settling.
// - Read-out stalls until meter data is delivered.
// - Single-scan misuse halts until reset or start.
// - Reprogramming a running scan returns home.
// - Continuous scan wraps from final to 1.
// - Random-mode advance sets ready, selects nothing.
// - Random programming while ready selects given channel.
// - Home clears counter, opens every channel.
`timescale 1ns/1ps
`include "scs_cfg.svh"

// Scanner channel sequencer. It follows programming, advance and read-out
// commands from the controller and keeps the channel, ready and halt state.
module scs_sequencer
(
  input  wire logic                    CLK,
  input  wire logic                    SRST,
  input  wire logic                    PROG_VALID,
  input  scs_pkg::scs_mode_t           PROG_MODE,
  input  wire logic [`SCS_CHAN_W-1:0]  PROG_CHAN,
  input  wire logic                    ADV_CMD,
  input  wire logic                    READ_CMD,
  input  wire logic                    METER_VALID,
  input  wire logic [`SCS_DATA_W-1:0]  METER_DATA,
  input  wire logic [`SCS_DELAY_W-1:0] CHAN_DELAY,
  input  wire logic                    CTRL_RESET,
  input  wire logic                    CTRL_START,
  output logic                         STORE_STROBE,
  output logic                         SETTLE_START,
  output logic                         SETTLE_BUSY,
  output logic                         MEAS_REQ,
  output logic [`SCS_CHAN_W-1:0]       CHAN_SEL,
  output logic                         READY,
  output logic                         HALT,
  output logic                         READ_STALL,
  output logic                         OUT_VALID,
  output logic [`SCS_DATA_W-1:0]       OUT_DATA
);
  import scs_pkg::*;

  logic [`SCS_CHAN_W-1:0] chan_ff;      // Selected channel, zero when home.
  logic [`SCS_CHAN_W-1:0] last_ff;      // Programmed final channel.
  scs_mode_t              mode_ff;      // Mode of the last programming command.
  logic                   ready_ff;     // Scanner ready state.
  logic                   halt_ff;      // System halted after a misuse.
  logic                   store_ff;     // Store-data strobe to the scanner.
  logic                   settle_ff;    // Start pulse for the settling delay.
  logic                   rd_pend_ff;   // Read-out waiting for meter data.
  logic                   have_ff;      // Meter data held for read-out.
  logic [`SCS_DATA_W-1:0] data_ff;      // Held meter data.
  logic                   out_vld_ff;   // Read-out word on the ASCII bus.
  logic [`SCS_DATA_W-1:0] out_data_ff;  // Word placed on the ASCII bus.
  logic                   end_read_ff;  // Single pass final channel read out.

  logic [`SCS_CHAN_W-1:0] nxt_chan;
  logic                   nxt_ready;

  // Decoded commands and conditions.
  wire clear_halt = CTRL_RESET | CTRL_START;
  wire is_scan    = (mode_ff == SCS_MODE_SINGLE) || (mode_ff == SCS_MODE_CONT);
  wire at_last    = (chan_ff == last_ff) && (chan_ff != `SCS_HOME_CHAN);
  wire prog_scan  = (PROG_MODE == SCS_MODE_SINGLE) || (PROG_MODE == SCS_MODE_CONT);
  // A second pass in single scan without reprogramming is a misuse.
  wire adv_bad    = ADV_CMD && !PROG_VALID && (mode_ff == SCS_MODE_SINGLE) && at_last;
  wire read_bad   = READ_CMD && end_read_ff;
  wire misuse     = ~halt_ff & ~clear_halt & (adv_bad | read_bad);
  // Commands are ignored while halted and in the cycle of a controller reset or start.
  wire live       = ~halt_ff & ~clear_halt;
  wire prog_ok    = live & PROG_VALID;
  wire adv_ok     = live & ADV_CMD & ~adv_bad & ~PROG_VALID;
  wire read_ok    = live & READ_CMD & ~read_bad;
  // Meter data is handed on once a read-out is waiting for it.
  wire deliver    = rd_pend_ff & have_ff & ~halt_ff;
  wire adv_sel    = adv_ok & (mode_ff != SCS_MODE_RANDOM);
  wire prog_sel   = prog_ok & ready_ff;
  wire meas_done;

  // Next channel after an advance: wrap only in continuous scan.
  function automatic logic [`SCS_CHAN_W-1:0] step_chan(
    input logic [`SCS_CHAN_W-1:0] cur,
    input logic [`SCS_CHAN_W-1:0] last,
    input logic                   wrap
  );
    logic [`SCS_CHAN_W-1:0] res;
    res = cur + `SCS_FIRST_CHAN;
    if (wrap && (cur == last))
    begin
      res = `SCS_FIRST_CHAN;
    end
    return res;
  endfunction

  // Channel and ready state for the next cycle.
  always_comb
  begin
    nxt_chan  = chan_ff;
    nxt_ready = ready_ff;
    if (CTRL_RESET)
    begin
      nxt_ready = 1'b0;
    end
    else if (prog_ok)
    begin
      if (!ready_ff)
      begin
        // Not ready: go home and wait for the next advance.
        nxt_chan = `SCS_HOME_CHAN;
      end
      else if (prog_scan)
      begin
        nxt_ready = 1'b0;
        nxt_chan  = `SCS_FIRST_CHAN;
      end
      else
      begin
        nxt_ready = 1'b0;
        nxt_chan  = PROG_CHAN;
      end
    end
    else if (adv_ok)
    begin
      if (mode_ff == SCS_MODE_RANDOM)
      begin
        // The channel is chosen by the programming command that follows.
        nxt_ready = 1'b1;
        nxt_chan  = `SCS_HOME_CHAN;
      end
      else
      begin
        nxt_chan = step_chan(chan_ff, last_ff, mode_ff == SCS_MODE_CONT);
      end
    end
  end

  // Sequencer state registers.
  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      chan_ff   <= `SCS_HOME_CHAN;
      ready_ff  <= 1'b0;
      last_ff   <= `SCS_LAST_RST;
      mode_ff   <= SCS_MODE_SINGLE;
      store_ff  <= 1'b0;
      settle_ff <= 1'b0;
    end
    else
    begin
      chan_ff   <= nxt_chan;
      ready_ff  <= nxt_ready;
      store_ff  <= prog_ok;
      // Settling starts from programming while ready or from an advance outside random mode.
      settle_ff <= (prog_sel & ~CTRL_RESET) | adv_sel;
      if (prog_ok)
      begin
        last_ff <= PROG_CHAN;
        mode_ff <= PROG_MODE;
      end
    end
  end

  // Halt state: set on a misuse, held until reset or start.
  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      halt_ff     <= 1'b0;
      end_read_ff <= 1'b0;
    end
    else
    begin
      halt_ff <= (halt_ff | misuse) & ~clear_halt;
      // Marks that the single pass is over, so a read-out now is a misuse.
      if (prog_ok || clear_halt)
      begin
        end_read_ff <= 1'b0;
      end
      else if (deliver && at_last && (mode_ff == SCS_MODE_SINGLE))
      begin
        end_read_ff <= 1'b1;
      end
    end
  end

  // Read-out path: the meter result is held until a read-out takes it.
  // The held word is kept only once; a newer meter result replaces it.
  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      rd_pend_ff  <= 1'b0;
      have_ff     <= 1'b0;
      data_ff     <= `SCS_DATA_RST;
      out_vld_ff  <= 1'b0;
      out_data_ff <= `SCS_DATA_RST;
    end
    else
    begin
      rd_pend_ff <= (rd_pend_ff | read_ok) & ~deliver & ~clear_halt;
      if (METER_VALID)
      begin
        have_ff <= 1'b1;
        data_ff <= METER_DATA;
      end
      else if (deliver || adv_sel || prog_sel)
      begin
        // A new channel makes any older result stale.
        have_ff <= 1'b0;
      end
      out_vld_ff <= deliver;
      if (deliver)
      begin
        out_data_ff <= data_ff;
      end
    end
  end

  // Settling delay and measurement request.
  scs_settle_timer u_settle
  (
    .clk   (CLK),
    .srst  (SRST),
    .start (settle_ff),
    .delay (CHAN_DELAY),
    .busy  (SETTLE_BUSY),
    .done  (meas_done)
  );

  assign STORE_STROBE = store_ff;
  assign SETTLE_START = settle_ff;
  assign MEAS_REQ     = meas_done & (chan_ff != `SCS_HOME_CHAN);
  assign CHAN_SEL     = chan_ff;
  assign READY        = ready_ff;
  assign HALT         = halt_ff;
  // The controller is held off while a read-out waits for the meter.
  assign READ_STALL   = rd_pend_ff & ~out_vld_ff;
  assign OUT_VALID    = out_vld_ff;
  assign OUT_DATA     = out_data_ff;

  // Programming while ready in a scan mode selects channel one.
  a_ready_prog_sel : assert property (@(posedge CLK) disable iff (SRST)
    prog_ok && ready_ff && prog_scan && !CTRL_RESET |=> CHAN_SEL == 8'h01 && !READY)
    else $error("Programming while ready did not select channel one.");

  // Programming while not ready sends the scanner home.
  a_not_ready_home : assert property (@(posedge CLK) disable iff (SRST)
    prog_ok && !ready_ff |=> CHAN_SEL == 8'h00)
    else $error("Programming while not ready left a channel selected.");

  // Store strobe follows the programming command, settling one cycle on.
  a_store_settle : assert property (@(posedge CLK) disable iff (SRST)
    prog_ok && ready_ff && !CTRL_RESET |=> STORE_STROBE && SETTLE_START ##1 SETTLE_BUSY)
    else $error("Store strobe or settling start missing after programming.");

  // Advance steps the channel by one and starts settling.
  a_adv_step : assert property (@(posedge CLK) disable iff (SRST)
    adv_sel && !CTRL_RESET && chan_ff != last_ff
      |=> CHAN_SEL == $past(chan_ff) + 8'h01 && SETTLE_START)
    else $error("Advance did not step to the next channel.");

  // Continuous scan wraps from the final channel to channel one.
  a_cont_wrap : assert property (@(posedge CLK) disable iff (SRST)
    adv_ok && mode_ff == SCS_MODE_CONT && chan_ff == last_ff |=> CHAN_SEL == 8'h01)
    else $error("Continuous scan did not wrap to channel one.");

  // Single scan advance past the final channel halts, channel held.
  a_single_halt : assert property (@(posedge CLK) disable iff (SRST)
    misuse |=> HALT && $stable(CHAN_SEL) ##1 (HALT || $past(clear_halt)))
    else $error("Single scan misuse did not halt the system.");

  // Random advance sets ready with no channel selected.
  a_random_ready : assert property (@(posedge CLK) disable iff (SRST)
    adv_ok && mode_ff == SCS_MODE_RANDOM && !CTRL_RESET |=> READY && CHAN_SEL == 8'h00)
    else $error("Random advance did not set ready.");

  // Random programming while ready selects the carried channel.
  a_random_sel : assert property (@(posedge CLK) disable iff (SRST)
    prog_ok && ready_ff && PROG_MODE == SCS_MODE_RANDOM && !CTRL_RESET
      |=> CHAN_SEL == $past(PROG_CHAN) && !READY)
    else $error("Random programming did not select the given channel.");

  // A stalled read-out stays stalled until data arrives.
  a_read_stall : assert property (@(posedge CLK) disable iff (SRST)
    READ_STALL && !have_ff && !METER_VALID && !clear_halt |=> READ_STALL && !OUT_VALID)
    else $error("Read-out stall released without meter data.");

  // Held data and a pending read-out put the word out next cycle.
  a_read_out : assert property (@(posedge CLK) disable iff (SRST)
    deliver |=> OUT_VALID && OUT_DATA == $past(data_ff))
    else $error("Read-out did not deliver the held word.");

  // Controller reset clears ready.
  a_reset_ready : assert property (@(posedge CLK) disable iff (SRST)
    CTRL_RESET |=> !READY && !HALT)
    else $error("Controller reset did not clear ready.");

endmodule

// >>> testbench/scs_meter_model.sv
`timescale 1ns/1ps
`include "scs_cfg.svh"

// Behavioural meter beside the scanner. Each measurement request is answered
// after a programmable latency with a word that names the channel measured.
module scs_meter_model
(
  input  wire logic                   clk,
  input  wire logic                   srst,
  input  wire logic                   meas_req,
  input  wire logic [`SCS_CHAN_W-1:0] chan_sel,
  input  wire logic [7:0]             lat,
  output logic                        meter_valid,
  output logic [`SCS_DATA_W-1:0]      meter_data
);
  logic [7:0]             cnt_ff;  // Cycles left before the answer.
  logic                   busy_ff; // A measurement is under way.
  logic [`SCS_DATA_W-1:0] word_ff; // Result that will be delivered.

  // Outside the valid pulse the data lines toggle every cycle, so a sequencer
  // that samples them at the wrong moment cannot pick up a stale word by luck.
  always_ff @(posedge clk)
  begin
    meter_valid <= 1'b0;
    if (srst)
    begin
      busy_ff    <= 1'b0;
      cnt_ff     <= 8'h00;
      meter_data <= 16'h0000;
    end
    else if (meas_req)
    begin
      busy_ff    <= 1'b1;
      cnt_ff     <= lat;
      word_ff    <= {8'ha5, chan_sel};
      meter_data <= ~meter_data;
    end
    else if (busy_ff && cnt_ff == 8'h00)
    begin
      busy_ff     <= 1'b0;
      meter_valid <= 1'b1;
      meter_data  <= word_ff;
    end
    else
    begin
      cnt_ff     <= busy_ff ? cnt_ff - 8'h01 : cnt_ff;
      meter_data <= ~meter_data;
    end
  end
endmodule

// >>> testbench/scs_sequencer_tb_top.sv
`timescale 1ns/1ps
`include "scs_cfg.svh"

// Bench for the channel sequencer: a table of commands, then timing cases.
module scs_sequencer_tb_top;
  import scs_pkg::*;
  localparam int         D  = 3;               // Settling delay in cycles.
  localparam logic [2:0] P  = 3'h0;            // Programming command.
  localparam logic [2:0] A  = 3'h1;            // Advance command.
  localparam logic [2:0] RS = 3'h3;            // Controller reset.
  localparam logic [2:0] ST = 3'h4;            // Controller start.
  localparam scs_mode_t  SG = SCS_MODE_SINGLE;
  localparam scs_mode_t  CT = SCS_MODE_CONT;
  localparam scs_mode_t  RN = SCS_MODE_RANDOM;
  // One command with the channel, ready, halt and strobe it should leave.
  typedef struct packed {
    logic [2:0] op; scs_mode_t mode; logic [7:0] chan;
    logic [7:0] e_chan; logic e_rdy; logic e_halt; logic e_stb;
  } scs_row_t;
  scs_row_t   rows [19];
  logic       clk, srst, prog_valid, adv_cmd, read_cmd, ctrl_reset, ctrl_start;
  scs_mode_t  prog_mode;
  logic [7:0] prog_chan, chan_sel;
  logic       meter_valid, store_strobe, settle_start, settle_busy, meas_req;
  logic       ready, halt, read_stall, out_valid, stall1;
  logic [15:0] meter_data, out_data;
  int         mismatches, n_compared, n;

  scs_sequencer u_dut (.CLK(clk), .SRST(srst), .PROG_VALID(prog_valid),
    .PROG_MODE(prog_mode), .PROG_CHAN(prog_chan), .ADV_CMD(adv_cmd),
    .READ_CMD(read_cmd), .METER_VALID(meter_valid), .METER_DATA(meter_data),
    .CHAN_DELAY(16'(D)), .CTRL_RESET(ctrl_reset), .CTRL_START(ctrl_start),
    .STORE_STROBE(store_strobe), .SETTLE_START(settle_start),
    .SETTLE_BUSY(settle_busy), .MEAS_REQ(meas_req), .CHAN_SEL(chan_sel),
    .READY(ready), .HALT(halt), .READ_STALL(read_stall), .OUT_VALID(out_valid),
    .OUT_DATA(out_data));
  scs_meter_model u_meter (.clk(clk), .srst(srst), .meas_req(meas_req),
    .chan_sel(chan_sel), .lat(8'h04), .meter_valid(meter_valid),
    .meter_data(meter_data));

  // Free-running 10 MHz clock.
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Compares one value and counts it.
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic tally_and_finish;
    $display("compared=%0d mismatches=%0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Drives one command for one cycle; returns just after the taking edge.
  task automatic run_row(input scs_row_t r);
    @(posedge clk);
    case (r.op)
      P:
      begin
        prog_valid <= 1'b1;
        prog_mode  <= r.mode;
        prog_chan  <= r.chan;
      end
      A:       adv_cmd    <= 1'b1;
      RS:      ctrl_reset <= 1'b1;
      default: ctrl_start <= 1'b1;
    endcase
    @(posedge clk);
    {prog_valid, adv_cmd, ctrl_reset, ctrl_start} <= 4'h0;
    #1;
  endtask

  // Issues a read-out and counts cycles until the word is delivered.
  task automatic do_read(output int cyc, output logic st1);
    @(posedge clk);
    read_cmd <= 1'b1;
    @(posedge clk);
    read_cmd <= 1'b0;
    cyc = 0;
    st1 = 1'b0;
    do
    begin
      @(posedge clk);
      #1;
      cyc++;
      if (cyc == 1)
        st1 = read_stall;
    end
    while (out_valid !== 1'b1 && cyc < 60);
  endtask

  // A hang is cut short at 20000 cycles, well beyond the fewer than a hundred cycles the tests need.
  initial
  begin
    #2000000;
    mismatches++;
    tally_and_finish;
  end

  initial
  begin
    {prog_valid, adv_cmd, read_cmd, ctrl_reset, ctrl_start} = 5'h00;
    prog_mode = SG; prog_chan = 8'h00; srst = 1'b1;
    mismatches = 0; n_compared = 0;
    rows = '{'{P,SG,8'h02,8'h00,1'b0,1'b0,1'b1},
             '{A,SG,8'h00,8'h01,1'b0,1'b0,1'b0},
             '{A,SG,8'h00,8'h02,1'b0,1'b0,1'b0},
             '{A,SG,8'h00,8'h02,1'b0,1'b1,1'b0},
             '{P,SG,8'h02,8'h02,1'b0,1'b1,1'b0},
             '{ST,SG,8'h00,8'h02,1'b0,1'b0,1'b0},
             '{P,CT,8'h02,8'h00,1'b0,1'b0,1'b1},
             '{A,CT,8'h00,8'h01,1'b0,1'b0,1'b0},
             '{A,CT,8'h00,8'h02,1'b0,1'b0,1'b0},
             '{A,CT,8'h00,8'h01,1'b0,1'b0,1'b0},
             '{P,CT,8'h02,8'h00,1'b0,1'b0,1'b1},
             '{A,CT,8'h00,8'h01,1'b0,1'b0,1'b0},
             '{P,RN,8'h07,8'h00,1'b0,1'b0,1'b1},
             '{A,RN,8'h00,8'h00,1'b1,1'b0,1'b0},
             '{P,RN,8'h07,8'h07,1'b0,1'b0,1'b1},
             '{A,RN,8'h00,8'h00,1'b1,1'b0,1'b0},
             '{RS,RN,8'h00,8'h00,1'b0,1'b0,1'b0},
             '{A,RN,8'h00,8'h00,1'b1,1'b0,1'b0},
             '{P,SG,8'h02,8'h01,1'b0,1'b0,1'b1}};
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    #1;
    check({8'h00, store_strobe, settle_start, settle_busy, meas_req,
           ready, halt, read_stall, out_valid}, 16'h0000);
    check({8'h00, chan_sel}, 16'h0000);
    $display("test done: reset");
    foreach (rows[i])
    begin
      run_row(rows[i]);
      check({8'h00, chan_sel}, {8'h00, rows[i].e_chan});
      check({15'h0, ready}, {15'h0, rows[i].e_rdy});
      check({15'h0, halt}, {15'h0, rows[i].e_halt});
      check({15'h0, store_strobe}, {15'h0, rows[i].e_stb});
    end
    $display("test done: command table");
    // The last row programmed a single scan while ready: settling starts now.
    check({15'h0, settle_start}, 16'h0001);
    n = 0;
    while (meas_req !== 1'b1 && n < 50)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    check(16'(n), 16'(D + 2));
    n = 0;
    while (meter_valid !== 1'b1 && n < 50)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    do_read(n, stall1);
    // Counted from the edge that takes the read: the word stands one edge later.
    check(16'(n), 16'h0001);
    check({15'h0, stall1}, 16'h0000);
    check(out_data, 16'ha501);
    $display("test done: read with data held");
    // Advance to the final channel and read at once, before the meter answers.
    run_row(rows[1]);
    do_read(n, stall1);
    check({15'h0, stall1}, 16'h0001);
    check({15'h0, read_stall}, 16'h0000);
    check(out_data, 16'ha502);
    $display("test done: stalled read");
    // A further read after the final channel has been delivered is misuse.
    @(posedge clk);
    read_cmd <= 1'b1;
    @(posedge clk);
    read_cmd <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check({15'h0, halt}, 16'h0001);
    run_row(rows[16]);
    check({15'h0, halt}, 16'h0000);
    $display("test done: halt on misuse");
    // A reset in mid-run must bring every output back to its idle value.
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    #1;
    check({8'h00, store_strobe, settle_start, settle_busy, meas_req,
           ready, halt, read_stall, out_valid}, 16'h0000);
    check({8'h00, chan_sel}, 16'h0000);
    check(out_data, 16'h0000);
    // Not ready after reset, so the first programming sends the scanner home.
    run_row(rows[0]);
    check({8'h00, chan_sel}, 16'h0000);
    check({15'h0, store_strobe}, 16'h0001);
    $display("test done: reset in mid-run");
    tally_and_finish;
  end
endmodule
